// File: shared/alu_pkg.sv
package alu_pkg;

    // ---------------------------------------------------------------
    // instruction word layout
    // ---------------------------------------------------------------
    localparam int INSTR_W = 16;
    localparam int OPC_MSB = 15; // 5-bit opcode
    localparam int OPC_LSB = 11;
    localparam int ROW_MSB = 10; // 3-bit data memory row
    localparam int ROW_LSB = 8;
    localparam int COL_MSB = 7; // 4-bit data memory column
    localparam int COL_LSB = 4;
    localparam int IMM_MSB = 3; // register column or immediate
    localparam int IMM_LSB = 0;

    // ---------------------------------------------------------------
    // opcodes
    // ---------------------------------------------------------------
    localparam logic [4:0] OP_ADD_RM = 5'h03;
    localparam logic [4:0] OP_SUM_CARRY_OP_RM = 5'h02;
    localparam logic [4:0] OP_ADD_MI = 5'h10;
    localparam logic [4:0] OP_SUM_CARRY_OP_MI = 5'h12;
    localparam logic [4:0] OP_SYS = 5'h07;
    localparam logic [2:0] SYS_ROW = 3'h0;
    localparam logic [3:0] SUB_INC_AR = 4'h9;
    localparam logic [3:0] SUB_INC_IX = 4'h8;
    localparam logic [3:0] SYS_LOW = 4'h0;

    // ---------------------------------------------------------------
    // widths
    // ---------------------------------------------------------------
    localparam int NIB = 4;
    localparam int DM_ADDR_W = 11; // bank 4, row 3, column 4
    localparam int IX_W = 12;
    localparam int AR_MAX = 16;
    localparam int PTR_W = 7; // bank 4, row 3

    // ---------------------------------------------------------------
    // register port indices
    // ---------------------------------------------------------------
    localparam logic [3:0] R_PSW = 4'h0;
    localparam logic [3:0] R_MODE = 4'h1;
    localparam logic [3:0] R_BANK = 4'h2;
    localparam logic [3:0] R_RPH = 4'h3;
    localparam logic [3:0] R_RPL = 4'h4;
    localparam logic [3:0] R_MPH = 4'h5;
    localparam logic [3:0] R_MPL = 4'h6;
    localparam logic [3:0] R_IXL = 4'h7;
    localparam logic [3:0] R_IXM = 4'h8;
    localparam logic [3:0] R_IXH = 4'h9;
    localparam logic [3:0] R_AR0 = 4'ha;
    localparam logic [3:0] R_AR3 = 4'hd;

    // ---------------------------------------------------------------
    // field positions and reset values
    // ---------------------------------------------------------------
    localparam int PSW_DEC = 0;
    localparam int PSW_DISC = 1;
    localparam int PSW_CY = 2;
    localparam int PSW_Z = 3;
    localparam int MODE_IXE = 0;
    localparam int MODE_MPE = 1;
    localparam logic [3:0] RST_NIB = 4'h0;
    localparam logic [4:0] BCD_LIMIT = 5'h09;
    localparam logic [4:0] BCD_ADJ = 5'h06;

endpackage

// File: shared/alu_if.sv
`timescale 1ns/1ps
// operands in, sum and carry out of the nibble adder
interface alu_if;
    import alu_pkg::*;
    logic [NIB-1:0] a; // first addend
    logic [NIB-1:0] b; // second addend
    logic cin; // carry in
    logic dec; // decimal digit mode
    logic [NIB-1:0] sum; // result nibble
    logic cout; // carry out
    modport calc (input a, input b, input cin, input dec,
                  output sum, output cout);
    modport user (output a, output b, output cin, output dec,
                  input sum, input cout);
endinterface

// File: verilog/nibble_adder.sv
`timescale 1ns/1ps
module nibble_adder
    import alu_pkg::*;
(
    alu_if.calc p
);
    // ---------------------------------------------------------------
    // binary or decimal nibble addition
    // ---------------------------------------------------------------
    logic [NIB:0] raw; // plain binary sum with carry
    logic [NIB:0] adj; // decimal corrected sum

    // a decimal digit above nine wraps by adding six and carries out
    always_comb begin
        raw = {1'b0, p.a} + {1'b0, p.b} + {{NIB{1'b0}}, p.cin};
        adj = raw + BCD_ADJ;
        if (p.dec && (raw > BCD_LIMIT)) begin
            p.sum = adj[NIB-1:0];
            p.cout = 1'b1;
        end else begin
            p.sum = raw[NIB-1:0];
            p.cout = raw[NIB];
        end
    end
endmodule

// File: verilog/nibble_add_increment_alu.sv
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/1ps
// Summary of operation
// - add immediate to memory, write sum back
// - discard flag set: no write, flags still updated
// - carry flag follows nibble carry out
// - nonzero result always clears null flag
// - zero result, discard clear: set null flag
// - zero result, discard set: null flag kept
// - decimal mode flag selects decimal digit arithmetic
// - register plus memory plus carry into register
// - memory plus immediate plus carry into memory
// - register operand uses low four address bits
// - index enable ORs index into memory address
// - pointer select clear ignores memory pointer
// - increment address register by one
// - address register increments as AR_WIDTH-bit value
// - increment index register by one
// - index register increments as 12-bit value
// - address register width is a parameter
module nibble_add_increment_alu
    import alu_pkg::*;
#(parameter int AR_WIDTH = AR_MAX)
(
    input wire logic CLK,
    input wire logic NRST,
    input wire logic EXEC,
    input wire logic [INSTR_W-1:0] INSTR,
    output logic BUSY,
    output logic DONE,
    output logic [DM_ADDR_W-1:0] MEM_ADDR,
    output logic MEM_RD,
    output logic MEM_WR,
    output logic [NIB-1:0] MEM_WDATA,
    input wire logic [NIB-1:0] MEM_RDATA,
    input wire logic [3:0] REG_ADDR,
    input wire logic [NIB-1:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [NIB-1:0] REG_RDATA,
    output logic CARRY,
    output logic ZERO,
    output logic [PTR_W-1:0] PTR_BASE
);
    // ---------------------------------------------------------------
    // reset release, state, decode and adder
    // ---------------------------------------------------------------
    logic rst_meta_ff; // first stage, read only by second
    logic rst_n; // synchronised active-low reset
    // release is synchronous so no flop sees a runt edge
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rst_meta_ff <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n <= rst_meta_ff;
        end
    end

    typedef enum {S_IDLE, S_MRD, S_MCAP, S_RRD, S_RCAP, S_EXE} state_e;
    state_e state_ff; // sequencer of one add
    logic dec_ff; // decimal mode flag
    logic discard_ff; // result discard flag
    logic carry_ff; // carry flag
    logic zero_ff; // null result flag
    logic ixe_ff; // index address enable
    logic mpe_ff; // pointer select enable
    logic [NIB-1:0] bank_ff; // data memory bank
    logic [NIB-1:0] rph_ff; // general register bank
    logic [2:0] rpl_ff; // general register row
    logic [PTR_W-1:0] mp_ff; // memory pointer
    logic [IX_W-1:0] ix_ff; // index register
    logic [AR_MAX-1:0] ar_ff; // address register
    logic rform_ff; // operand pair is register and memory
    logic use_cy_ff; // carry flag joins the sum
    logic [NIB-1:0] imm_ff; // immediate field
    logic [NIB-1:0] opa_ff; // first addend
    logic [NIB-1:0] opb_ff; // second addend
    logic [DM_ADDR_W-1:0] madr_ff; // effective memory address
    logic [DM_ADDR_W-1:0] radr_ff; // general register address
    logic busy_ff;
    logic done_ff;
    logic [DM_ADDR_W-1:0] mem_addr_ff;
    logic mem_rd_ff;
    logic mem_wr_ff;
    logic [NIB-1:0] mem_wdata_ff;
    logic [NIB-1:0] rdata_ff;
    logic [PTR_W-1:0] ptr_base_ff;

    logic [4:0] opc; // opcode field of the offered word
    logic is_sys; // system group with fixed fields
    logic take; // a word is accepted this cycle
    logic add_go; // accepted add
    logic inc_ar_go; // accepted address register increment
    logic inc_ix_go; // accepted index register increment
    logic [DM_ADDR_W-1:0] nxt_madr; // effective operand address
    logic [AR_MAX-1:0] ar_mask; // implemented address bits
    logic [AR_MAX-1:0] nxt_ar;
    logic [IX_W-1:0] nxt_ix;
    assign opc = INSTR[OPC_MSB:OPC_LSB];
    assign take = EXEC && (state_ff == S_IDLE);
    assign is_sys = (opc == OP_SYS) && (INSTR[ROW_MSB:ROW_LSB] == SYS_ROW)
        && (INSTR[IMM_MSB:IMM_LSB] == SYS_LOW);
    assign add_go = take && ((opc == OP_ADD_RM) || (opc == OP_SUM_CARRY_OP_RM) ||
        (opc == OP_ADD_MI) || (opc == OP_SUM_CARRY_OP_MI));
    assign inc_ar_go = take && is_sys &&
        (INSTR[COL_MSB:COL_LSB] == SUB_INC_AR);
    assign inc_ix_go = take && is_sys &&
        (INSTR[COL_MSB:COL_LSB] == SUB_INC_IX);
    // the index ORs into the memory operand only
    assign nxt_madr = {bank_ff, INSTR[ROW_MSB:ROW_LSB],
        INSTR[COL_MSB:COL_LSB]} |
        (ixe_ff ? ix_ff[DM_ADDR_W-1:0] : '0);
    // unimplemented address register bits stay at zero
    assign ar_mask = AR_MAX'((32'h1 << AR_WIDTH) - 32'h1);
    // whole-word increments carry through every nibble at once
    assign nxt_ar = (ar_ff + AR_MAX'(1)) & ar_mask;
    assign nxt_ix = ix_ff + IX_W'(1);
    alu_if add_io (); // nibble adder operands and result
    assign add_io.a = opa_ff;
    assign add_io.b = opb_ff;
    assign add_io.cin = use_cy_ff & carry_ff;
    assign add_io.dec = dec_ff;
    nibble_adder u_add (
        .p (add_io.calc)
    );

    // ---------------------------------------------------------------
    // sequencer and memory port
    // ---------------------------------------------------------------
    // memory read, optional register read, then sum and write-back
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= S_IDLE;
            rform_ff <= 1'b0;
            use_cy_ff <= 1'b0;
            imm_ff <= RST_NIB;
            opa_ff <= RST_NIB;
            opb_ff <= RST_NIB;
            madr_ff <= '0;
            radr_ff <= '0;
            mem_addr_ff <= '0;
            mem_rd_ff <= 1'b0;
            mem_wr_ff <= 1'b0;
            mem_wdata_ff <= RST_NIB;
            done_ff <= 1'b0;
            busy_ff <= 1'b0;
        end else begin
            mem_rd_ff <= 1'b0;
            mem_wr_ff <= 1'b0;
            done_ff <= 1'b0;
            case (state_ff)
                S_IDLE: begin
                    if (add_go) begin
                        rform_ff <= !opc[4];
                        use_cy_ff <= (opc == OP_SUM_CARRY_OP_RM) ||
                            (opc == OP_SUM_CARRY_OP_MI);
                        imm_ff <= INSTR[IMM_MSB:IMM_LSB];
                        madr_ff <= nxt_madr;
                        mem_addr_ff <= nxt_madr;
                        // only the low four bits name the column
                        radr_ff <= {rph_ff, rpl_ff,
                            INSTR[IMM_MSB:IMM_LSB]};
                        mem_rd_ff <= 1'b1;
                        busy_ff <= 1'b1;
                        state_ff <= S_MRD;
                    end else if (inc_ar_go || inc_ix_go) begin
                        done_ff <= 1'b1;
                    end
                end
                S_MRD: state_ff <= S_MCAP;
                S_MCAP: begin
                    opa_ff <= MEM_RDATA;
                    if (rform_ff) begin
                        opb_ff <= MEM_RDATA;
                        mem_addr_ff <= radr_ff;
                        mem_rd_ff <= 1'b1;
                        state_ff <= S_RRD;
                    end else begin
                        opb_ff <= imm_ff;
                        state_ff <= S_EXE;
                    end
                end
                S_RRD: state_ff <= S_RCAP;
                S_RCAP: begin
                    opa_ff <= MEM_RDATA;
                    state_ff <= S_EXE;
                end
                S_EXE: begin
                    // a compare run keeps its destination untouched
                    if (!discard_ff) begin
                        mem_addr_ff <= rform_ff ? radr_ff : madr_ff;
                        mem_wdata_ff <= add_io.sum;
                        mem_wr_ff <= 1'b1;
                    end
                    done_ff <= 1'b1;
                    busy_ff <= 1'b0;
                    state_ff <= S_IDLE;
                end
                default: begin
                    busy_ff <= 1'b0;
                    state_ff <= S_IDLE;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // status flags and modes
    // ---------------------------------------------------------------
    // the adder wins over a software write landing in the same cycle
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            carry_ff <= 1'b0;
            zero_ff <= 1'b0;
            dec_ff <= 1'b0;
            discard_ff <= 1'b0;
        end else begin
            if (REG_WR && (REG_ADDR == R_PSW)) begin
                dec_ff <= REG_WDATA[PSW_DEC];
                discard_ff <= REG_WDATA[PSW_DISC];
            end
            if (state_ff == S_EXE) begin
                carry_ff <= add_io.cout;
                if (add_io.sum != RST_NIB) begin
                    zero_ff <= 1'b0;
                end else if (!discard_ff) begin
                    zero_ff <= 1'b1;
                end
                // zero with discard set keeps the flag
            end else if (REG_WR && (REG_ADDR == R_PSW)) begin
                carry_ff <= REG_WDATA[PSW_CY];
                zero_ff <= REG_WDATA[PSW_Z];
            end
        end
    end
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            ixe_ff <= 1'b0;
            mpe_ff <= 1'b0;
            bank_ff <= RST_NIB;
            rph_ff <= RST_NIB;
            rpl_ff <= '0;
            mp_ff <= '0;
        end else if (REG_WR) begin
            case (REG_ADDR)
                R_MODE: begin
                    ixe_ff <= REG_WDATA[MODE_IXE];
                    mpe_ff <= REG_WDATA[MODE_MPE];
                end
                R_BANK: bank_ff <= REG_WDATA;
                R_RPH: rph_ff <= REG_WDATA;
                R_RPL: rpl_ff <= REG_WDATA[2:0];
                R_MPH: mp_ff[PTR_W-1:3] <= REG_WDATA;
                R_MPL: mp_ff[2:0] <= REG_WDATA[2:0];
                default: ;
            endcase
        end
    end
    // ---------------------------------------------------------------
    // index and address registers
    // ---------------------------------------------------------------
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            ix_ff <= '0;
        end else if (inc_ix_go) begin
            ix_ff <= nxt_ix;
        end else if (REG_WR && (REG_ADDR == R_IXL)) begin
            ix_ff[3:0] <= REG_WDATA;
        end else if (REG_WR && (REG_ADDR == R_IXM)) begin
            ix_ff[7:4] <= REG_WDATA;
        end else if (REG_WR && (REG_ADDR == R_IXH)) begin
            ix_ff[11:8] <= REG_WDATA;
        end
    end
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            ar_ff <= '0;
        end else if (inc_ar_go) begin
            ar_ff <= nxt_ar;
        end else if (REG_WR && (REG_ADDR >= R_AR0) &&
                     (REG_ADDR <= R_AR3)) begin
            // each nibble loads alone; missing bits are masked off
            for (int i = 0; i < AR_MAX / NIB; i++) begin
                if (REG_ADDR[1:0] == 2'(i + 2)) begin
                    ar_ff[i*NIB +: NIB] <= REG_WDATA &
                        ar_mask[i*NIB +: NIB];
                end
            end
        end
    end
    // ---------------------------------------------------------------
    // read port and pointer output
    // ---------------------------------------------------------------
    // read data stands only in the cycle after the strobe
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= RST_NIB;
        end else if (REG_RD) begin
            case (REG_ADDR)
                R_PSW: rdata_ff <= {zero_ff, carry_ff, discard_ff, dec_ff};
                R_MODE: rdata_ff <= {2'h0, mpe_ff, ixe_ff};
                R_BANK: rdata_ff <= bank_ff;
                R_RPH: rdata_ff <= rph_ff;
                R_RPL: rdata_ff <= {1'b0, rpl_ff};
                R_MPH: rdata_ff <= mp_ff[PTR_W-1:3];
                R_MPL: rdata_ff <= {1'b0, mp_ff[2:0]};
                R_IXL: rdata_ff <= ix_ff[3:0];
                R_IXM: rdata_ff <= ix_ff[7:4];
                R_IXH: rdata_ff <= ix_ff[11:8];
                4'ha: rdata_ff <= ar_ff[3:0];
                4'hb: rdata_ff <= ar_ff[7:4];
                4'hc: rdata_ff <= ar_ff[11:8];
                R_AR3: rdata_ff <= ar_ff[15:12];
                default: rdata_ff <= RST_NIB;
            endcase
        end else begin
            rdata_ff <= RST_NIB;
        end
    end
    // base row for general register indirect transfers
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            ptr_base_ff <= '0;
        end else begin
            ptr_base_ff <= mpe_ff ? mp_ff : {bank_ff, rpl_ff};
        end
    end
    assign BUSY = busy_ff;
    assign DONE = done_ff;
    assign MEM_ADDR = mem_addr_ff;
    assign MEM_RD = mem_rd_ff;
    assign MEM_WR = mem_wr_ff;
    assign MEM_WDATA = mem_wdata_ff;
    assign REG_RDATA = rdata_ff;
    assign CARRY = carry_ff;
    assign ZERO = zero_ff;
    assign PTR_BASE = ptr_base_ff;
endmodule

// File: verification/alu_checker.sv
`timescale 1ns/1ps
// ---------------------------------------------
// port checker
// ---------------------------------------------
module alu_checker
    import alu_pkg::*;
(
    input wire logic CLK,
    input wire logic NRST,
    input wire logic EXEC,
    input wire logic [INSTR_W-1:0] INSTR,
    input wire logic BUSY,
    input wire logic DONE,
    input wire logic [DM_ADDR_W-1:0] MEM_ADDR,
    input wire logic MEM_RD,
    input wire logic MEM_WR,
    input wire logic [NIB-1:0] MEM_WDATA,
    input wire logic [3:0] REG_ADDR,
    input wire logic [NIB-1:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic CARRY,
    input wire logic ZERO
);
    localparam logic [15:0] INC_AR_W = {OP_SYS, SYS_ROW, SUB_INC_AR, SYS_LOW};
    localparam logic [15:0] INC_IX_W = {OP_SYS, SYS_ROW, SUB_INC_IX, SYS_LOW};
    logic [4:0] opc; // opcode field of the offered word
    logic disc_ff; // shadow of the discard bit, only software sets it
    assign opc = INSTR[OPC_MSB:OPC_LSB];
    // track port writes, as the flag is invisible at the ports
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            disc_ff <= 1'b0;
        end else if (REG_WR && REG_ADDR == R_PSW) begin
            disc_ff <= REG_WDATA[PSW_DISC];
        end
    end
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!NRST);
    // ---------------------------------------------
    // accepted requests
    // ---------------------------------------------
    sequence s_take_mi;
        EXEC && !BUSY && (opc == OP_ADD_MI || opc == OP_SUM_CARRY_OP_MI);
    endsequence
    sequence s_take_rm;
        EXEC && !BUSY && (opc == OP_ADD_RM || opc == OP_SUM_CARRY_OP_RM);
    endsequence
    sequence s_take_inc;
        EXEC && !BUSY && (INSTR == INC_AR_W || INSTR == INC_IX_W);
    endsequence
    a_mi_timing: assert property (
        s_take_mi |=> BUSY [*3] ##1 (DONE && !BUSY))
        else $error("immediate add latency wrong");
    a_rm_timing: assert property (
        s_take_rm |=> BUSY [*5] ##1 (DONE && !BUSY))
        else $error("register add latency wrong");
    a_inc_done: assert property (
        s_take_inc |=> DONE && !MEM_RD && !MEM_WR)
        else $error("increment not done in one cycle");
    a_inc_flags: assert property (
        s_take_inc |=> $stable(CARRY) && $stable(ZERO))
        else $error("increment touched flags");
    a_rd_pulse: assert property (
        MEM_RD |-> BUSY ##1 (!MEM_RD && BUSY))
        else $error("memory read not a lone pulse");
    a_wr_at_done: assert property (
        MEM_WR |-> DONE && MEM_ADDR == $past(MEM_ADDR, 3))
        else $error("write back misplaced");
    a_disc_nowr: assert property (DONE && disc_ff |-> !MEM_WR)
        else $error("write while discard set");
    a_zero_match: assert property (
        MEM_WR |-> ZERO == (MEM_WDATA == 4'h0))
        else $error("null flag disagrees with result");
    a_flag_quiet: assert property (
        $changed(CARRY) |-> DONE || $past(REG_WR))
        else $error("carry moved without cause");
endmodule
bind nibble_add_increment_alu alu_checker alu_checker_inst (
    .CLK(CLK), .NRST(NRST), .EXEC(EXEC), .INSTR(INSTR), .BUSY(BUSY),
    .DONE(DONE), .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD), .MEM_WR(MEM_WR),
    .MEM_WDATA(MEM_WDATA), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .CARRY(CARRY), .ZERO(ZERO));

// File: verification/dmem_model.sv
`timescale 1ns/1ps
// ---------------------------------------------
// data memory on the far side
// ---------------------------------------------
module dmem_model
    import alu_pkg::*;
(
    input wire logic clk,
    input wire logic rd,
    input wire logic wr,
    input wire logic [DM_ADDR_W-1:0] addr,
    input wire logic [NIB-1:0] wdata,
    output logic [NIB-1:0] rdata
);
    logic [NIB-1:0] mem [0:(1<<DM_ADDR_W)-1]; // preloaded by the bench
    initial rdata = 4'h0;
    // data only in the cycle after a read; elsewhere the line toggles,
    // so a late sample of stale data cannot pass for a good read
    always @(posedge clk) begin
        if (wr) begin
            mem[addr] <= wdata;
        end
        if (rd) begin
            rdata <= mem[addr];
        end else begin
            rdata <= ~rdata;
        end
    end
endmodule

// File: verification/nibble_add_increment_alu_tb.sv
`timescale 1ns/1ps
`define MEM dmem_model_inst.mem
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
    bad_count++; $display("Error %s exp %h got %h", n, e, g); end end
module nibble_add_increment_alu_tb
    import alu_pkg::*;
;
    localparam int AR_W = 14; // narrower than full, drops top bits
    localparam logic [15:0] AR_MASK = 16'((1 << AR_W) - 1);
    localparam logic [15:0] INC_AR = {OP_SYS, SYS_ROW, SUB_INC_AR, SYS_LOW};
    localparam logic [15:0] INC_IX = {OP_SYS, SYS_ROW, SUB_INC_IX, SYS_LOW};
    logic clk = 1'b0;
    logic nrst, exec, busy, done, mem_rd, mem_wr, reg_wr, reg_rd;
    logic carry, zero;
    logic [15:0] instr;
    logic [10:0] mem_addr;
    logic [3:0] mem_wdata, mem_rdata, reg_addr, reg_wdata, reg_rdata;
    logic [6:0] ptr_base;
    int bad_count = 0;
    int cmp_count = 0;
    always #4 clk = ~clk;
    nibble_add_increment_alu #(.AR_WIDTH(AR_W)) nibble_add_increment_alu_inst (
        .CLK(clk), .NRST(nrst), .EXEC(exec), .INSTR(instr), .BUSY(busy),
        .DONE(done), .MEM_ADDR(mem_addr), .MEM_RD(mem_rd), .MEM_WR(mem_wr),
        .MEM_WDATA(mem_wdata), .MEM_RDATA(mem_rdata), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_RDATA(reg_rdata), .CARRY(carry), .ZERO(zero),
        .PTR_BASE(ptr_base));
    dmem_model dmem_model_inst (.clk(clk), .rd(mem_rd), .wr(mem_wr),
        .addr(mem_addr), .wdata(mem_wdata), .rdata(mem_rdata));
    // ---------------------------------------------
    // bus and instruction tasks
    // ---------------------------------------------
    function automatic logic [15:0] iw(input logic [4:0] o,
        input logic [2:0] r, input logic [3:0] c, input logic [3:0] n);
        return {o, r, c, n};
    endfunction
    task wr(input logic [3:0] a, input logic [3:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [3:0] a, input logic [3:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        `CHK("reg", e, reg_rdata)
    endtask
    // offer a word for n cycles, then wait (bounded) for completion
    task ex(input logic [15:0] w, input int n);
        int i;
        @(posedge clk);
        exec <= 1'b1;
        instr <= w;
        repeat (n) @(posedge clk);
        exec <= 1'b0;
        i = 0;
        #1;
        while (done !== 1'b1 && i < 20) begin
            @(posedge clk);
            #1;
            i++;
        end
        `CHK("done", 1'b1, done)
        @(posedge clk); // let the write back land in memory
        #1;
    endtask
    // ---------------------------------------------
    // scenarios
    // ---------------------------------------------
    task t_add;
        rd(4'he, 4'h0); // unmapped index reads zero
        `MEM[11'h02f] = 4'hc;
        ex(iw(OP_ADD_MI, 3'h2, 4'hf, 4'h5), 1);
        `CHK("mem", 4'h1, `MEM[11'h02f])
        `CHK("cy", 1'b1, carry)
        `CHK("z", 1'b0, zero)
        `MEM[11'h02f] = 4'hf;
        ex(iw(OP_SUM_CARRY_OP_MI, 3'h2, 4'hf, 4'h0), 1);
        `CHK("mem", 4'h0, `MEM[11'h02f])
        `CHK("z", 1'b1, zero)
        rd(R_PSW, 4'hc);
        $display("add test done");
    endtask
    task t_disc;
        wr(R_PSW, 4'ha); // null flag up, discard on
        `MEM[11'h030] = 4'h3;
        ex(iw(OP_ADD_MI, 3'h3, 4'h0, 4'h4), 1);
        `CHK("mem", 4'h3, `MEM[11'h030])
        `CHK("z", 1'b0, zero)
        `MEM[11'h031] = 4'h8;
        ex(iw(OP_ADD_MI, 3'h3, 4'h1, 4'h8), 1);
        `CHK("mem", 4'h8, `MEM[11'h031])
        `CHK("cy", 1'b1, carry)
        `CHK("z", 1'b0, zero)
        wr(R_PSW, 4'h1); // decimal digits, discard off
        `MEM[11'h032] = 4'h7;
        ex(iw(OP_ADD_MI, 3'h3, 4'h2, 4'h5), 1);
        `CHK("mem", 4'h2, `MEM[11'h032])
        `CHK("cy", 1'b1, carry)
        $display("discard and decimal test done");
    endtask
    task t_rm;
        wr(R_PSW, 4'h4); // carry in set: plain add must ignore it
        wr(R_MODE, 4'h1);
        wr(R_IXM, 4'h4);
        wr(R_RPL, 4'h1);
        `MEM[11'h06f] = 4'h9;
        `MEM[11'h013] = 4'h4;
        ex(iw(OP_ADD_RM, 3'h2, 4'hf, 4'h3), 1);
        `CHK("reg", 4'hd, `MEM[11'h013])
        `MEM[11'h06f] = 4'h5;
        ex(iw(OP_SUM_CARRY_OP_RM, 3'h2, 4'hf, 4'h3), 1);
        `CHK("reg", 4'h2, `MEM[11'h013])
        ex(iw(OP_SUM_CARRY_OP_RM, 3'h2, 4'hf, 4'h3), 1);
        `CHK("reg", 4'h8, `MEM[11'h013])
        wr(R_MODE, 4'h0);
        $display("register add test done");
    endtask
    task t_inc;
        logic [15:0] e;
        e = ((16'heffe & AR_MASK) + 16'h0002) & AR_MASK;
        for (int i = 0; i < 4; i++) begin
            wr(R_AR0 + 4'(i), 4'(16'heffe >> (4 * i)));
        end
        ex(INC_AR, 2); // two increments back to back
        for (int i = 0; i < 4; i++) begin
            rd(R_AR0 + 4'(i), 4'(e >> (4 * i)));
        end
        for (int i = 0; i < 3; i++) begin
            wr(R_IXL + 4'(i), 4'(12'h0ff >> (4 * i)));
        end
        ex(INC_IX, 1);
        for (int i = 0; i < 3; i++) begin
            rd(R_IXL + 4'(i), 4'(12'h100 >> (4 * i)));
        end
        $display("increment test done");
    endtask
    task t_ptr;
        wr(R_BANK, 4'h5);
        wr(R_RPL, 4'h3);
        wr(R_MPH, 4'ha);
        wr(R_MPL, 4'h6);
        repeat (2) @(posedge clk);
        #1;
        `CHK("ptr", 7'h2b, ptr_base)
        wr(R_MODE, 4'h2);
        repeat (2) @(posedge clk);
        #1;
        `CHK("ptr", 7'h56, ptr_base)
        $display("pointer test done");
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // a hang would otherwise never end the run
    initial begin
        #40000;
        bad_count++;
        $display("Error watchdog expired");
        stop_test;
    end
    initial begin
        nrst = 1'b0;
        exec = 1'b0;
        instr = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 4'h0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        t_add;
        t_disc;
        t_rm;
        t_inc;
        t_ptr;
        stop_test;
    end
endmodule
